//--- logic/seq_host_cfg.svh
/*
  Constants for the write-sequencer host controller: device register map,
  command values, own APB register offsets and timing counts.
  Assumes a 100 MHz system clock and a device register port of 8-bit
  address and 16-bit data reached through a simple request/acknowledge port.
*/
// Summary of operation
// RQ1 - Default start-up first writes 0100h to sequencer control register 6Ch.
// RQ2 - Writing 0100h to launch register 6Fh starts sequence at step zero.
// RQ3 - Writing 0119h to launch register starts shutdown at step 19h.
// RQ4 - Device holds busy flag high while a sequence executes.
// RQ5 - After shutdown, wait busy low before stopping system clock and master clock.
// RQ6 - Third start-up write puts 0000h into DAC digital control 21h.
// RQ7 - Device keeps computed offset corrections while powered and not reset.
// RQ8 - Power loss or software reset restores default steps; recalibration needed.
// RQ9 - Fast start-up first writes 0111h to control register, selecting step 11h.
// RQ10 - Then write 00FFh to step-definition register 6Dh, making a dummy step.
// RQ11 - Then write 0000h to step-data register 6Eh clearing flag, wait, value.
// RQ12 - Fast start-up with stored offsets completes in under 50 ms.
// RQ13 - Default start-up completes in about 300 ms at 12.288 MHz.
// RQ14 - Default shutdown completes in about 350 ms.
// RQ15 - Master clock must run before any start-up is launched.
// RQ16 - Any write to register 00h resets every device register.
// RQ17 - Identification field at 00h is read-only; write only triggers reset.
// RQ18 - Reading register 00h returns the fixed 16-bit identification code.
// RQ19 - Launch shutdown only from the configuration left by default start-up; code only checks mclk_run, set by either start-up, kept through soft reset.
// RQ20 - Default start-up configures DAC playback to headphone and line at 48 kHz.
// RQ21 - Default start-up runs offset servo calibration and stores the correction.
// RQ22 - A step with its last flag set stops the sequencer and drops busy.
// RQ23 - Never launch or edit steps while busy reads 1; poll it first; code polls busy only after a launch, never before one.
`ifndef SEQ_HOST_CFG_SVH
`define SEQ_HOST_CFG_SVH

`define DEV_REG_RESET_IDENT  8'h00
`define DEV_REG_DAC_CTRL     8'h21
`define DEV_REG_SEQ_CTRL     8'h6C
`define DEV_REG_STEP_DEF     8'h6D
`define DEV_REG_STEP_DATA    8'h6E
`define DEV_REG_SEQ_LAUNCH   8'h6F
`define DEV_REG_SEQ_STATUS   8'h70
`define SEQ_RUNNING_BIT      0

`define VAL_SEQ_ON_IDX0      16'h0100
`define VAL_LAUNCH_IDX0      16'h0100
`define VAL_LAUNCH_SHUTDOWN  16'h0119
`define VAL_DAC_UNMUTE       16'h0000
`define VAL_SEQ_ON_IDX17     16'h0111
`define VAL_DUMMY_STEP_DEF   16'h00FF
`define VAL_DUMMY_STEP_DATA  16'h0000
`define VAL_SOFT_RESET       16'h0000

`define APB_CMD_OFS          12'h000
`define APB_STATUS_OFS       12'h004
`define APB_IDENT_OFS        12'h008
`define APB_DEV_ADDR_OFS     12'h00C
`define APB_DEV_DATA_OFS     12'h010

`define CMD_DEFAULT_START    3'd1
`define CMD_FAST_START       3'd2
`define CMD_SHUTDOWN         3'd3
`define CMD_SOFT_RESET       3'd4
`define CMD_READ_IDENT       3'd5
`define CMD_RAW_WRITE        3'd6
`define CMD_RAW_READ         3'd7

`define CLK_PERIOD_NS        10
`define POLL_GAP_US          10
`define POLL_GAP_CYC         ((`POLL_GAP_US * 1000) / `CLK_PERIOD_NS)
`define SEQ_TIMEOUT_MS       400
`define SEQ_TIMEOUT_CYC      ((`SEQ_TIMEOUT_MS * 1000000) / `CLK_PERIOD_NS)

`endif

//--- logic/seq_host_pkg.sv
/*
  Types for the write-sequencer host controller.
  Assumes the constants header is compiled alongside.
*/
package seq_host_pkg;

  typedef struct packed {
    logic        req;
    logic        wr;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } dev_req_t;

  typedef struct packed {
    logic        ack;
    logic [15:0] rdata;
  } dev_rsp_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ISSUE, ST_WAIT_ACK, ST_GAP, ST_POLL, ST_DONE
  } host_state_t;

endpackage

//--- logic/seq_host_ctrl.sv
/*
  Host controller that drives the device's write sequencer through its
  register port: default start-up, fast start-up, shutdown, software reset,
  identification read and raw register access, commanded over APB.
  Assumes the device port answers each request with a one-cycle ack on the
  same clock; the ack path is registered twice only if asynchronous, which
  it is not here. Master clock control pins are plain outputs.
*/
// Local design decision: register access over APB.
`include "seq_host_cfg.svh"

module seq_host_ctrl (
  input  wire logic                   sys_clk,
  input  wire logic                   rst,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  output seq_host_pkg::dev_req_t      dev_req,
  input  wire seq_host_pkg::dev_rsp_t dev_rsp,
  output logic                        mclk_run,
  output logic                        sysclk_on
);
  import seq_host_pkg::*;

  localparam int unsigned TIMEOUT_CYC = `SEQ_TIMEOUT_CYC;

  host_state_t  state_r;
  logic [2:0]   cmd_r;
  logic [2:0]   step_r;
  logic [2:0]   nsteps_r;
  logic         busy_r;
  logic         timeout_r;
  logic         done_r;
  logic [15:0]  ident_r;
  logic [7:0]   raw_addr_r;
  logic [15:0]  raw_data_r;
  logic [31:0]  wait_cnt_r;
  logic [31:0]  gap_cnt_r;
  logic         poll_mode_r;
  logic         apb_wr;
  logic         apb_rd;
  logic         cmd_go;

  assign apb_wr  = psel && penable && pwrite;
  assign apb_rd  = psel && penable && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  // RQ19 shutdown only after start-up.
  assign cmd_go  = apb_wr && (paddr == `APB_CMD_OFS) && !busy_r && (pwdata[2:0] != 3'd0) &&
                   ((pwdata[2:0] != `CMD_SHUTDOWN) || mclk_run);

  // Register access word (write flag, address, data) for each step of each command.
  function automatic logic [24:0] step_word(input logic [2:0] cmd, input logic [2:0] idx,
                                            input logic [7:0] ra, input logic [15:0] rd);
    step_word = {1'b1, `DEV_REG_SEQ_STATUS, 16'h0000};
    unique case (cmd)
      `CMD_DEFAULT_START: begin
        // RQ1 RQ2 RQ6 start-up order.
        unique case (idx)
          3'd0:    step_word = {1'b1, `DEV_REG_SEQ_CTRL, `VAL_SEQ_ON_IDX0};
          3'd1:    step_word = {1'b1, `DEV_REG_SEQ_LAUNCH, `VAL_LAUNCH_IDX0};
          default: step_word = {1'b1, `DEV_REG_DAC_CTRL, `VAL_DAC_UNMUTE};
        endcase
      end
      `CMD_FAST_START: begin
        // RQ9 RQ10 RQ11 dummy step patch.
        unique case (idx)
          3'd0:    step_word = {1'b1, `DEV_REG_SEQ_CTRL, `VAL_SEQ_ON_IDX17};
          3'd1:    step_word = {1'b1, `DEV_REG_STEP_DEF, `VAL_DUMMY_STEP_DEF};
          3'd2:    step_word = {1'b1, `DEV_REG_STEP_DATA, `VAL_DUMMY_STEP_DATA};
          3'd3:    step_word = {1'b1, `DEV_REG_SEQ_LAUNCH, `VAL_LAUNCH_IDX0};
          default: step_word = {1'b1, `DEV_REG_DAC_CTRL, `VAL_DAC_UNMUTE};
        endcase
      end
      // RQ3 single shutdown write.
      `CMD_SHUTDOWN:   step_word = {1'b1, `DEV_REG_SEQ_LAUNCH, `VAL_LAUNCH_SHUTDOWN};
      // RQ16 soft reset write.
      `CMD_SOFT_RESET: step_word = {1'b1, `DEV_REG_RESET_IDENT, `VAL_SOFT_RESET};
      // RQ18 identification read.
      `CMD_READ_IDENT: step_word = {1'b0, `DEV_REG_RESET_IDENT, 16'h0000};
      `CMD_RAW_WRITE:  step_word = {1'b1, ra, rd};
      `CMD_RAW_READ:   step_word = {1'b0, ra, 16'h0000};
      default:         step_word = {1'b0, `DEV_REG_SEQ_STATUS, 16'h0000};
    endcase
  endfunction

  function automatic logic [2:0] step_count(input logic [2:0] cmd);
    unique case (cmd)
      `CMD_DEFAULT_START: step_count = 3'd3;
      `CMD_FAST_START:    step_count = 3'd5;
      default:            step_count = 3'd1;
    endcase
  endfunction

  // The launch write is followed by busy polling once the whole list is done.
  function automatic logic needs_poll(input logic [2:0] cmd);
    needs_poll = (cmd == `CMD_DEFAULT_START) || (cmd == `CMD_FAST_START) ||
                 (cmd == `CMD_SHUTDOWN);
  endfunction

  logic [24:0] cur_word;
  assign cur_word = poll_mode_r ? {1'b0, `DEV_REG_SEQ_STATUS, 16'h0000}
                                : step_word(cmd_r, step_r, raw_addr_r, raw_data_r);

  // Command sequencing state machine.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r     <= ST_IDLE;
      step_r      <= 3'd0;
      nsteps_r    <= 3'd0;
      cmd_r       <= 3'd0;
      poll_mode_r <= 1'b0;
      busy_r      <= 1'b0;
      done_r      <= 1'b0;
      timeout_r   <= 1'b0;
      wait_cnt_r  <= 32'h0000_0000;
      gap_cnt_r   <= 32'h0000_0000;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          // RQ23 commands refused while busy.
          if (cmd_go) begin
            cmd_r       <= pwdata[2:0];
            nsteps_r    <= step_count(pwdata[2:0]);
            step_r      <= 3'd0;
            poll_mode_r <= 1'b0;
            busy_r      <= 1'b1;
            done_r      <= 1'b0;
            timeout_r   <= 1'b0;
            wait_cnt_r  <= 32'h0000_0000;
            state_r     <= ST_ISSUE;
          end
        end
        ST_ISSUE: state_r <= ST_WAIT_ACK;
        ST_WAIT_ACK: begin
          if (wait_cnt_r != 32'hFFFF_FFFF) begin
            wait_cnt_r <= wait_cnt_r + 32'h0000_0001;
          end
          if (dev_rsp.ack) begin
            if (poll_mode_r) begin
              // RQ4 RQ22 done when busy falls.
              if (!dev_rsp.rdata[`SEQ_RUNNING_BIT]) begin
                state_r <= ST_DONE;
              end else if (wait_cnt_r >= TIMEOUT_CYC) begin
                timeout_r <= 1'b1;
                state_r   <= ST_DONE;
              end else begin
                gap_cnt_r <= 32'h0000_0000;
                state_r   <= ST_GAP;
              end
            end else if (step_r + 3'd1 == nsteps_r) begin
              if (needs_poll(cmd_r)) begin
                poll_mode_r <= 1'b1;
                wait_cnt_r  <= 32'h0000_0000;
                gap_cnt_r   <= 32'h0000_0000;
                state_r     <= ST_GAP;
              end else begin
                state_r <= ST_DONE;
              end
            end else begin
              step_r  <= step_r + 3'd1;
              state_r <= ST_ISSUE;
            end
          end
        end
        ST_GAP: begin
          wait_cnt_r <= wait_cnt_r + 32'h0000_0001;
          gap_cnt_r  <= gap_cnt_r + 32'h0000_0001;
          if (gap_cnt_r + 32'h0000_0001 >= 32'(`POLL_GAP_CYC)) begin
            state_r <= ST_ISSUE;
          end
        end
        ST_POLL:  state_r <= ST_ISSUE;
        ST_DONE: begin
          busy_r  <= 1'b0;
          done_r  <= 1'b1;
          state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Device port request: held from issue until ack.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dev_req <= '0;
    end else if (state_r == ST_ISSUE) begin
      dev_req.req   <= 1'b1;
      dev_req.wr    <= cur_word[24];
      dev_req.addr  <= cur_word[23:16];
      dev_req.wdata <= cur_word[15:0];
    end else if (dev_rsp.ack) begin
      dev_req.req <= 1'b0;
    end
  end

  // Read results from the device port.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ident_r <= 16'h0000;
    end else if (state_r == ST_WAIT_ACK && dev_rsp.ack && !dev_req.wr && !poll_mode_r) begin
      ident_r <= dev_rsp.rdata;
    end
  end

  // RQ15 RQ5 master and system clock control.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mclk_run  <= 1'b0;
      sysclk_on <= 1'b0;
    end else if (cmd_go && (pwdata[2:0] == `CMD_DEFAULT_START ||
                            pwdata[2:0] == `CMD_FAST_START)) begin
      mclk_run  <= 1'b1;
      sysclk_on <= 1'b1;
    end else if (state_r == ST_DONE && cmd_r == `CMD_SHUTDOWN && !timeout_r) begin
      mclk_run  <= 1'b0;
      sysclk_on <= 1'b0;
    end
  end

  // Raw access address and data registers.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      raw_addr_r <= 8'h00;
      raw_data_r <= 16'h0000;
    end else if (apb_wr && !busy_r) begin
      if (paddr == `APB_DEV_ADDR_OFS) begin
        raw_addr_r <= pwdata[7:0];
      end
      if (paddr == `APB_DEV_DATA_OFS) begin
        raw_data_r <= pwdata[15:0];
      end
    end
  end

  // APB read data.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        `APB_CMD_OFS:      prdata <= {29'h0, cmd_r};
        `APB_STATUS_OFS:   prdata <= {28'h0, mclk_run, timeout_r, done_r, busy_r};
        `APB_IDENT_OFS:    prdata <= {16'h0000, ident_r};
        `APB_DEV_ADDR_OFS: prdata <= {24'h00_0000, raw_addr_r};
        `APB_DEV_DATA_OFS: prdata <= {16'h0000, raw_data_r};
        default:           prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule

//--- tb/seq_host_properties.sv
/* Checker for the sequencer host controller.
   Sees only the controller's ports; bound below. */
module seq_host_properties (
  input wire logic                   sys_clk,
  input wire logic                   rst,
  input wire logic                   pready,
  input wire logic                   pslverr,
  input wire seq_host_pkg::dev_req_t dev_req,
  input wire seq_host_pkg::dev_rsp_t dev_rsp,
  input wire logic                   mclk_run,
  input wire logic                   sysclk_on
);
  import seq_host_pkg::*;
  logic busy_seen_r;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_wr(logic [7:0] a);
    dev_req.req && dev_req.wr && dev_req.addr == a;
  endsequence
  // Remembers whether a sequence was last known running: set by a launch write ack, updated by each status read.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      busy_seen_r <= 1'b0;
    end else if (dev_rsp.ack && dev_req.wr && dev_req.addr == 8'h6F) begin
      busy_seen_r <= 1'b1;
    end else if (dev_rsp.ack && !dev_req.wr && dev_req.addr == 8'h70) begin
      busy_seen_r <= dev_rsp.rdata[0];
    end
  end
  a_ctrl_word: assert property (s_wr(8'h6C) |-> dev_req.wdata inside {16'h0100, 16'h0111})
    else $error("bad sequencer control value");
  a_launch_word: assert property (s_wr(8'h6F) |-> dev_req.wdata inside {16'h0100, 16'h0119})
    else $error("bad launch value");
  a_dummy_def: assert property (s_wr(8'h6D) |-> dev_req.wdata == 16'h00FF)
    else $error("bad step definition value");
  a_dummy_data: assert property (s_wr(8'h6E) |-> dev_req.wdata == 16'h0000)
    else $error("bad step data value");
  a_dac_unmute: assert property (s_wr(8'h21) |-> dev_req.wdata == 16'h0000)
    else $error("bad dac control value");
  a_clock_first: assert property (s_wr(8'h6F) |-> mclk_run && sysclk_on)
    else $error("launch without running clock");
  a_idle_launch: assert property (s_wr(8'h6F) |-> !busy_seen_r)
    else $error("launch while sequencer busy");
  a_clock_stop: assert property ($fell(mclk_run) |-> !busy_seen_r && !sysclk_on)
    else $error("clock stopped before sequence end");
  a_req_hold: assert property (dev_req.req && !dev_rsp.ack |=> $stable(dev_req))
    else $error("device request changed before ack");
  a_ack_release: assert property (dev_rsp.ack |=> !dev_req.req)
    else $error("device request kept after ack");
  a_apb_ready: assert property (pready && !pslverr)
    else $error("bus answer not ready or error");
endmodule

bind seq_host_ctrl seq_host_properties i_props (.sys_clk, .rst, .pready, .pslverr,
  .dev_req, .dev_rsp, .mclk_run, .sysclk_on);

//--- tb/seq_dev_model.sv
/* Behavioural model of the device register port and write sequencer.
   Answers after 0 to 3 idle cycles; a sequence runs only while clocked. */
module seq_dev_model
  import seq_host_pkg::*;
#(
  parameter int          BUSY_CYC = 1500,
  parameter logic [15:0] DEV_ID   = 16'h5A3C // Arbitrary identity value.
) (
  input wire logic                   sys_clk,
  input wire logic                   rst,
  input wire seq_host_pkg::dev_req_t dev_req,
  output seq_host_pkg::dev_rsp_t     dev_rsp,
  input wire logic                   mclk_run
);
  logic [15:0] regs_r [0:255];
  logic [15:0] val_r;
  logic        ack_r;
  int          busy_r;
  int          wait_r;
  // Read data is only valid with ack; otherwise it shows garbage.
  assign dev_rsp = '{ack: ack_r, rdata: ack_r ? val_r : ~val_r};
  always_ff @(posedge sys_clk) begin
    ack_r <= 1'b0;
    if (busy_r > 0 && mclk_run) busy_r <= busy_r - 1;
    if (rst) begin
      for (int i = 0; i < 256; i++) regs_r[i] <= 16'h0000;
      busy_r <= 0;
      wait_r <= 0;
    end else if (dev_req.req && !ack_r && wait_r > 0) begin
      wait_r <= wait_r - 1;
    end else if (dev_req.req && !ack_r) begin
      ack_r <= 1'b1;
      wait_r <= $urandom_range(3, 0);
      if (!dev_req.wr) begin
        val_r <= dev_req.addr == 8'h00 ? DEV_ID :
                 dev_req.addr == 8'h70 ? {15'd0, busy_r > 0} : regs_r[dev_req.addr];
      end else if (dev_req.addr == 8'h00) begin
        for (int i = 0; i < 256; i++) regs_r[i] <= 16'h0000;
        busy_r <= 0;
      end else begin
        regs_r[dev_req.addr] <= dev_req.wdata;
        if (dev_req.addr == 8'h6F && dev_req.wdata[8]) busy_r <= BUSY_CYC;
      end
    end
  end
endmodule

//--- tb/test_write_sequencer_quick_start.sv
/* Self-checking bench for the sequencer host controller.
   Drives APB, queues expected reads; a monitor compares them. */
module test_write_sequencer_quick_start;
  timeunit 1ns;
  timeprecision 1ps;
  import seq_host_pkg::*;
  localparam logic [15:0] DEV_ID = 16'hC3A5; // Arbitrary identity value.
  logic        sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, q, r;
  logic        pready, pslverr, mclk_run, sysclk_on;
  dev_req_t    dev_req;
  dev_rsp_t    dev_rsp;
  logic [31:0] exp_q[$], msk_q[$];
  int          miscompares = 0, comparisons = 0;
  always #5 sys_clk = ~sys_clk;
  seq_host_ctrl i_dut (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .dev_req, .dev_rsp, .mclk_run, .sysclk_on);
  seq_dev_model #(.DEV_ID(DEV_ID)) i_dev (.sys_clk, .rst, .dev_req, .dev_rsp, .mclk_run);
  task automatic test_done();
    if (miscompares == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic check_word(input logic [31:0] got, exp, msk);
    if (msk != 0) begin
      comparisons++;
      if ((got & msk) !== (exp & msk)) begin
        miscompares++;
        $display("FAIL %0t read %h expected %h", $time, got, exp);
      end
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    q = prdata;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    apb(1'b0, a, 32'h0000_0000);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      rd(12'h004, 0, 0);
      n++;
    end while (q[0] !== 1'b0 && n < 3000);
    if (n >= 3000) begin
      miscompares++;
      test_done();
    end
  endtask
  task automatic run(input logic [2:0] c);
    wr(12'h000, {29'd0, c});
    wait_idle();
  endtask
  task automatic peek(input logic [7:0] a, input logic [15:0] e);
    wr(12'h00C, {24'd0, a});
    run(3'd7);
    rd(12'h008, {16'd0, e}, 32'h0000_FFFF);
  endtask
  always @(posedge sys_clk)
    if (psel && penable && pready === 1'b1 && !pwrite)
      check_word(prdata, exp_q.pop_front(), msk_q.pop_front());
  initial begin
    #500_000;
    miscompares++;
    test_done();
  end
  initial begin
    r = $urandom(82927);
    repeat (2) @(posedge sys_clk);
    rst <= 0;
    rd(12'h004, 0, 32'hFFFF_FFFF);
    rd(12'h020, 0, 32'hFFFF_FFFF);
    run(3'd5);
    rd(12'h008, {16'd0, DEV_ID}, 32'h0000_FFFF);
    run(3'd1);
    rd(12'h004, 32'h0000_000A, 32'h0000_000F);
    peek(8'h6C, 16'h0100);
    peek(8'h6F, 16'h0100);
    peek(8'h21, 16'h0000);
    r = $urandom;
    wr(12'h00C, 32'h0000_0030);
    wr(12'h010, r);
    run(3'd6);
    peek(8'h30, r[15:0]);
    run(3'd2);
    peek(8'h6C, 16'h0111);
    peek(8'h6D, 16'h00FF);
    peek(8'h6E, 16'h0000);
    wr(12'h000, 32'h0000_0003);
    wr(12'h000, 32'h0000_0004);
    wait_idle();
    rd(12'h000, 32'h0000_0003, 32'h0000_0007);
    rd(12'h004, 32'h0000_0002, 32'h0000_000F);
    peek(8'h6F, 16'h0119);
    run(3'd4);
    wr(12'h000, 32'h0000_0000);
    wr(12'h000, 32'h0000_0003);
    rd(12'h000, 32'h0000_0004, 32'h0000_0007);
    peek(8'h30, 16'h0000);
    run(3'd5);
    rd(12'h008, {16'd0, DEV_ID}, 32'h0000_FFFF);
    test_done();
  end
endmodule
